// File: verilog/ialc_regs.svh
// register offsets, field positions, reset values and timing counts of the level controller
`ifndef IALC_REGS_SVH
`define IALC_REGS_SVH
`define IALC_OFF_CTRL 4'h0
`define IALC_OFF_TIME 4'h4
`define IALC_OFF_STAT 4'h8
`define IALC_CTRL_EN_LSB 0
`define IALC_CTRL_MODE_BIT 2
`define IALC_CTRL_FLOOR_LSB 3
`define IALC_CTRL_CEIL_LSB 6
`define IALC_TIME_TGT_LSB 0
`define IALC_TIME_HOLD_LSB 4
`define IALC_TIME_DROP_LSB 8
`define IALC_TIME_RISE_LSB 12
`define IALC_STAT_GR_LSB 8
`define IALC_STAT_EMERG_BIT 16
`define IALC_STAT_LIM_BIT 17
`define IALC_RST_EN 2'h0
`define IALC_RST_FLOOR 3'h0
`define IALC_RST_CEIL 3'h7
`define IALC_RST_TGT 4'hb
`define IALC_RST_HOLD 4'h0
`define IALC_RST_DROP 4'h2
`define IALC_RST_RISE 4'h3
`define IALC_RST_GAIN 6'h10
`define IALC_EMERG_LVL 16'he000
`define IALC_CLK_MHZ 200
`define IALC_TICK_NS 31250
`define IALC_TICK_CYC ((`IALC_TICK_NS * `IALC_CLK_MHZ) / 1000)
`define IALC_SH_DROP_NRM 5'h2
`define IALC_SH_DROP_LIM 5'h0
`define IALC_SH_RISE_NRM 5'h4
`define IALC_SH_RISE_LIM 5'h2
`define IALC_SH_HOLD 5'h5
`define IALC_CODE_MAX 4'ha
`define IALC_PEAK_DSH 8
`endif

// File: verilog/ialc_pkg.sv
// types and shared arithmetic of the level controller
`default_nettype none
package ialc_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_STEADY = 2'b01,
    ST_DROP = 2'b10,
    ST_RISE = 2'b11
  } ialc_state_t;

  typedef struct packed {
    logic [1:0] chan_en;
    logic mode;
    logic [2:0] floor;
    logic [2:0] ceil;
    logic [3:0] target;
    logic [3:0] hold;
    logic [3:0] drop;
    logic [3:0] rise;
  } ialc_cfg_t;

  typedef struct packed {
    logic valid;
    logic signed [23:0] data;
  } ialc_smp_t;

  // interval in ticks: 2^(base+code), code clipped to ten doublings
  function automatic logic [19:0] ialc_ticks(input logic [3:0] code, input logic [4:0] base);
    logic [3:0] c;
    c = (code > 4'ha) ? 4'ha : code;
    return 20'h1 << (base + {1'b0, c});
  endfunction : ialc_ticks

  // level threshold in top 16 magnitude bits, -24 dBFS upward in 1.5 dB
  function automatic logic [15:0] ialc_level(input logic [4:0] idx);
    logic [15:0] v;
    v = 16'h1027;
    case (idx)
      5'h01: v = 16'h1334;
      5'h02: v = 16'h16d0;
      5'h03: v = 16'h1b1d;
      5'h04: v = 16'h203a;
      5'h05: v = 16'h264e;
      5'h06: v = 16'h2d84;
      5'h07: v = 16'h3617;
      5'h08: v = 16'h404e;
      5'h09: v = 16'h4c6a;
      5'h0a: v = 16'h5ad5;
      5'h0b: v = 16'h6bf4;
      5'h0c: v = 16'h804d;
      5'h0d: v = 16'h9880;
      5'h0e: v = 16'hb53b;
      5'h0f: v = 16'hd766;
      5'h10: v = 16'hd766;
      default: v = 16'h1027;
    endcase
    return v;
  endfunction : ialc_level
endpackage : ialc_pkg
`default_nettype wire

// File: verilog/ialc_peak_det.sv
// decaying peak detector on decimated samples of one channel
`timescale 1ns/1ps
`default_nettype none
`include "ialc_regs.svh"
module ialc_peak_det #(
  parameter int W = 24,
  parameter int DSH = `IALC_PEAK_DSH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ialc_pkg::ialc_smp_t smp_i,
  output logic valid_o,
  output logic [W-2:0] mag_o,
  output logic [W-2:0] peak_o
);
  logic [W-1:0] neg;
  logic [W-2:0] mag;
  logic [W-2:0] mag_ff;
  logic [W-2:0] peak_ff;
  logic valid_ff;
  logic [W-2:0] nxt_peak;

  // absolute value, most negative code clipped to full scale
  assign neg = W'(-smp_i.data);
  assign mag = !smp_i.data[W-1] ? smp_i.data[W-2:0] : (neg[W-1] ? {(W-1){1'b1}} : neg[W-2:0]);
  // larger sample replaces peak, otherwise peak decays geometrically
  assign nxt_peak = (mag > peak_ff) ? mag : (peak_ff - (peak_ff >> DSH) - ((peak_ff != '0 && (peak_ff >> DSH) == '0) ? (W-1)'(1) : '0));

  // sample-rate update of instant magnitude and peak
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mag_ff <= '0;
      peak_ff <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= smp_i.valid;
      if (smp_i.valid)
      begin
        mag_ff <= mag;
        peak_ff <= nxt_peak;
      end
    end
  end

  assign valid_o = valid_ff;
  assign mag_o = mag_ff;
  assign peak_o = peak_ff;
endmodule : ialc_peak_det
`default_nettype wire

// File: verilog/ialc_interval.sv
// saturating tick counter that flags when a programmed interval has passed
`timescale 1ns/1ps
`default_nettype none
module ialc_interval #(
  parameter int W = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);
  logic [W-1:0] count_ff;

  // restart on clear, count ticks, hold at the top
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      count_ff <= '0;
    else if (tick_i && count_ff != {W{1'b1}})
      count_ff <= count_ff + W'(1);
  end

  assign done_o = (count_ff >= limit_i);
endmodule : ialc_interval
`default_nettype wire

// File: verilog/ialc_level_ctrl.sv
// automatic level control loop for the stereo input amplifier gain
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ialc_regs.svh"
module ialc_level_ctrl #(
  parameter int TICK_CYCLES = `IALC_TICK_CYC,
  parameter int SW = 24
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic SMP_VALID_I,
  input wire logic signed [SW-1:0] SMP_LEFT_I,
  input wire logic signed [SW-1:0] SMP_RIGHT_I,
  input wire logic [1:0] AMP_EN_I,
  output logic [5:0] GAIN_LEFT_O,
  output logic [5:0] GAIN_RIGHT_O
);
  ialc_pkg::ialc_cfg_t cfg_ff;
  ialc_pkg::ialc_state_t state_ff, nxt_state;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [5:0] gain_ff, gain_l_ff, gain_r_ff, cap_ff;
  logic lim_ff, emerg_ff;
  logic [15:0] tick_cnt_ff;
  logic tick;
  logic vl;
  logic [SW-2:0] mag_l, mag_r, peak_l, peak_r;

  // bus decode and answer: one wait cycle per access
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire hit_ctrl = (AVS_ADDRESS_I == `IALC_OFF_CTRL);
  wire hit_time = (AVS_ADDRESS_I == `IALC_OFF_TIME);
  wire hit_stat = (AVS_ADDRESS_I == `IALC_OFF_STAT);
  wire take = req & ack_ff;
  wire [31:0] rd_mux = hit_ctrl ? 32'({cfg_ff.ceil, cfg_ff.floor, cfg_ff.mode, cfg_ff.chan_en}) :
                       hit_time ? 32'({cfg_ff.rise, cfg_ff.drop, cfg_ff.hold, cfg_ff.target}) :
                       hit_stat ? {14'h0, lim_ff, emerg_ff, 2'h0, gain_r_ff, 2'h0, gain_l_ff} : 32'h0;
  assign AVS_WAITREQUEST_O = req & ~ack_ff;
  assign AVS_READDATA_O = rdata_ff;

  // acknowledge flop and registered read data
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (AVS_READ_I && !ack_ff)
        rdata_ff <= rd_mux;
    end
  end

  // configuration registers, written on the accepting edge
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      cfg_ff <= '{`IALC_RST_EN, 1'b0, `IALC_RST_FLOOR, `IALC_RST_CEIL,
                  `IALC_RST_TGT, `IALC_RST_HOLD, `IALC_RST_DROP, `IALC_RST_RISE};
    else if (take && AVS_WRITE_I && hit_ctrl)
    begin
      cfg_ff.chan_en <= AVS_WRITEDATA_I[`IALC_CTRL_EN_LSB +: 2];
      cfg_ff.mode <= AVS_WRITEDATA_I[`IALC_CTRL_MODE_BIT];
      cfg_ff.floor <= AVS_WRITEDATA_I[`IALC_CTRL_FLOOR_LSB +: 3];
      cfg_ff.ceil <= AVS_WRITEDATA_I[`IALC_CTRL_CEIL_LSB +: 3];
    end
    else if (take && AVS_WRITE_I && hit_time)
    begin
      cfg_ff.target <= AVS_WRITEDATA_I[`IALC_TIME_TGT_LSB +: 4];
      cfg_ff.hold <= AVS_WRITEDATA_I[`IALC_TIME_HOLD_LSB +: 4];
      cfg_ff.drop <= AVS_WRITEDATA_I[`IALC_TIME_DROP_LSB +: 4];
      cfg_ff.rise <= AVS_WRITEDATA_I[`IALC_TIME_RISE_LSB +: 4];
    end
  end

  // per-channel magnitude and decaying peak of decimated samples
  ialc_peak_det #(.W(SW)) u_peak_l (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .smp_i('{SMP_VALID_I, SMP_LEFT_I}),
    .valid_o(vl),
    .mag_o(mag_l),
    .peak_o(peak_l)
  );
  ialc_peak_det #(.W(SW)) u_peak_r (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .smp_i('{SMP_VALID_I, SMP_RIGHT_I}),
    .valid_o(),
    .mag_o(mag_r),
    .peak_o(peak_r)
  );

  // channel selection and levels of the enabled channels
  wire en_l = cfg_ff.chan_en[1];
  wire en_r = cfg_ff.chan_en[0];
  wire enabled = en_l | en_r;
  wire limiting = enabled & cfg_ff.mode;
  wire [15:0] inst_l = en_l ? mag_l[SW-2 -: 16] : 16'h0;
  wire [15:0] inst_r = en_r ? mag_r[SW-2 -: 16] : 16'h0;
  wire [15:0] pk_l = en_l ? peak_l[SW-2 -: 16] : 16'h0;
  wire [15:0] pk_r = en_r ? peak_r[SW-2 -: 16] : 16'h0;
  wire [15:0] inst = (inst_l > inst_r) ? inst_l : inst_r;
  wire [15:0] pk = (pk_l > pk_r) ? pk_l : pk_r;
  wire eval = vl & enabled;

  // level comparisons: instant for attack, decaying peak for release
  wire [15:0] tgt_lvl = ialc_pkg::ialc_level({1'b0, cfg_ff.target} + 5'h1);
  wire [15:0] low_lvl = ialc_pkg::ialc_level({1'b0, cfg_ff.target});
  wire over = inst > tgt_lvl;
  wire under = pk <= low_lvl;
  wire emerg = inst > `IALC_EMERG_LVL;

  // gain window from floor, ceiling or captured limiter bound
  wire [5:0] lower = {cfg_ff.floor, 3'h0};
  // on the entry cycle the capture is not in place yet, so the present gain bounds a rise
  wire [5:0] lim_bound = lim_ff ? cap_ff : gain_ff;
  wire [5:0] upper = limiting ? lim_bound : {cfg_ff.ceil, 3'h7};

  // interval selection, limiter tables four times faster
  wire [19:0] drop_iv = ialc_pkg::ialc_ticks(cfg_ff.drop, limiting ? `IALC_SH_DROP_LIM : `IALC_SH_DROP_NRM);
  wire [19:0] rise_iv = ialc_pkg::ialc_ticks(cfg_ff.rise, limiting ? `IALC_SH_RISE_LIM : `IALC_SH_RISE_NRM);
  wire [19:0] hold_iv = (cfg_ff.hold == 4'h0) ? 20'h0 : ialc_pkg::ialc_ticks(cfg_ff.hold, `IALC_SH_HOLD);
  wire [19:0] step_iv = emerg ? 20'h1 : (nxt_state == ialc_pkg::ST_RISE) ? rise_iv : drop_iv;
  logic step_done, hold_done;

  // decision per sample: drop, continue dropping, rise or stay
  always_comb
  begin
    nxt_state = state_ff;
    if (!enabled)
      nxt_state = ialc_pkg::ST_OFF;
    else if (eval)
    begin
      if (emerg || over)
        nxt_state = ialc_pkg::ST_DROP;
      else if (state_ff == ialc_pkg::ST_DROP && !under)
        nxt_state = ialc_pkg::ST_DROP;
      else if (under)
        nxt_state = ialc_pkg::ST_RISE;
      else
        nxt_state = ialc_pkg::ST_STEADY;
    end
  end

  // step requests, bounded by the gain window
  wire step_dn = eval && nxt_state == ialc_pkg::ST_DROP && step_done && gain_ff > lower;
  wire step_up = eval && nxt_state == ialc_pkg::ST_RISE && step_done && hold_done && gain_ff < upper;
  wire iv_clr = step_dn | step_up | (eval & (nxt_state != state_ff));

  // tick prescaler shared by the interval counters
  assign tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));
  always_ff @(posedge CLK_I)
  begin
    if (RST_I || tick)
      tick_cnt_ff <= 16'h0;
    else
      tick_cnt_ff <= tick_cnt_ff + 16'h1;
  end

  // time between gain steps
  ialc_interval u_step_iv (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .clear_i(iv_clr),
    .tick_i(tick),
    .limit_i(step_iv),
    .done_o(step_done)
  );
  // time the peak must stay under target before a rise
  ialc_interval u_hold_iv (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .clear_i(eval & ~under),
    .tick_i(tick),
    .limit_i(hold_iv),
    .done_o(hold_done)
  );

  // loop state, shared gain, limiter capture and emergency flag
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state_ff <= ialc_pkg::ST_OFF;
      gain_ff <= `IALC_RST_GAIN;
      cap_ff <= `IALC_RST_GAIN;
      lim_ff <= 1'b0;
      emerg_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      lim_ff <= limiting;
      if (limiting && !lim_ff)
        cap_ff <= gain_ff;
      if (eval)
        emerg_ff <= emerg;
      if (step_dn)
        gain_ff <= gain_ff - 6'h1;
      else if (step_up)
        gain_ff <= gain_ff + 6'h1;
    end
  end

  // per-channel gain follows only while channel and amplifier are on
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      gain_l_ff <= `IALC_RST_GAIN;
      gain_r_ff <= `IALC_RST_GAIN;
    end
    else
    begin
      if (en_l && AMP_EN_I[1])
        gain_l_ff <= gain_ff;
      if (en_r && AMP_EN_I[0])
        gain_r_ff <= gain_ff;
    end
  end

  assign GAIN_LEFT_O = gain_l_ff;
  assign GAIN_RIGHT_O = gain_r_ff;

  // checks on the loop and the bus
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  floor_hold_a: assert property (step_dn |-> ##1 gain_ff >= lower)
    else $error("gain stepped under floor");
  ceil_hold_a: assert property (step_up && !limiting |-> gain_ff < {cfg_ff.ceil, 3'h7})
    else $error("gain raised at ceiling");
  lim_cap_a: assert property (limiting && $past(limiting) && $changed(gain_ff) |-> gain_ff <= cap_ff)
    else $error("limiter bound exceeded");
  emerg_drop_a: assert property (eval && emerg && step_done && gain_ff > lower |=> gain_ff == $past(gain_ff) - 6'h1)
    else $error("emergency drop missing");
  one_step_a: assert property ($changed(gain_ff) |-> $past(eval))
    else $error("gain moved without a sample");
  hold_rise_a: assert property (step_up |-> hold_done && under && !over)
    else $error("rise before hold or above target");
  drop_cause_a: assert property (step_dn |-> over || emerg || !under)
    else $error("drop without cause");
  off_still_a: assert property (!enabled |=> $stable(gain_ff))
    else $error("gain moved while disabled");
  amp_freeze_a: assert property (!AMP_EN_I[1] |=> $stable(gain_l_ff))
    else $error("left gain moved with amp off");
  steady_keep_a: assert property (eval && !over && !under && state_ff != ialc_pkg::ST_DROP |=> $stable(gain_ff))
    else $error("gain moved at target");
  bus_answer_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("bus answer late");

  // limiter capture, enables and release checks
  cap_take_a: assert property (limiting && !lim_ff |=> cap_ff == $past(gain_ff))
    else $error("limiter bound not captured");
  rise_bound_a: assert property (step_up && limiting |-> gain_ff < cap_ff)
    else $error("limiter rise at captured bound");
  off_state_a: assert property (!enabled |=> state_ff == ialc_pkg::ST_OFF)
    else $error("loop active while disabled");
  drop_halt_a: assert property (eval && under && !over && !emerg |=> state_ff == ialc_pkg::ST_RISE)
    else $error("drop kept going under release level");
  amp_freeze_r_a: assert property (!AMP_EN_I[0] |=> $stable(gain_r_ff))
    else $error("right gain moved with amp off");
  lim_fast_a: assert property (limiting && cfg_ff.drop == 4'h0 |-> drop_iv == 20'h1)
    else $error("limiter drop interval not shortened");

  // scenarios the bench should reach
  drop_seen_c: cover property (step_dn ##1 state_ff == ialc_pkg::ST_DROP);
  steady_seen_c: cover property (eval && nxt_state == ialc_pkg::ST_STEADY);
  rise_seen_c: cover property (step_up);
  emerg_seen_c: cover property (eval && emerg && step_dn);
  lim_seen_c: cover property (limiting && !lim_ff);
endmodule : ialc_level_ctrl
`default_nettype wire

// File: verif/ialc_amp_model.sv
// behavioural input amplifier and converter feeding decimated stereo samples
`timescale 1ns/1ps
`default_nettype none
module ialc_amp_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] gain_left_i,
  input wire logic [5:0] gain_right_i,
  input wire logic [19:0] lvl_i,
  output logic valid_o,
  output logic signed [23:0] left_o,
  output logic signed [23:0] right_o
);
  logic [1:0] div_ff;
  logic neg_ff;
  logic [25:0] amp_l;
  logic [25:0] amp_r;
  logic [23:0] s_l;
  logic [23:0] s_r;
  // one sample every fourth cycle, sign alternates per sample
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_ff <= 2'h0;
      neg_ff <= 1'b0;
    end
    else
    begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3)
        neg_ff <= ~neg_ff;
    end
  end
  // gain scales the input level, converter clips at full scale
  assign amp_l = 26'(lvl_i) * 26'(gain_left_i);
  assign amp_r = 26'(lvl_i) * 26'(gain_right_i);
  assign s_l = (amp_l > 26'h7fffff) ? 24'h7fffff : amp_l[23:0];
  assign s_r = (amp_r > 26'h7fffff) ? 24'h7fffff : amp_r[23:0];
  assign valid_o = (div_ff == 2'h3);
  // between strobes the lines carry the inverted magnitude, not the last sample
  assign left_o = valid_o ? (neg_ff ? -s_l : s_l) : ~s_l;
  assign right_o = valid_o ? (neg_ff ? -s_r : s_r) : ~s_r;
endmodule : ialc_amp_model
`default_nettype wire

// File: verif/ialc_level_ctrl_test.sv
// self-checking testbench of the level controller with amplifier model
`timescale 1ns/1ps
`default_nettype none
module input_automatic_level_control_test;
  logic clk;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_rq;
  logic smp_v;
  logic signed [23:0] smp_l;
  logic signed [23:0] smp_r;
  logic [1:0] amp_en = 2'h3;
  logic [5:0] g_l;
  logic [5:0] g_r;
  logic [19:0] lvl = 20'h0;
  logic [31:0] d;
  logic [5:0] held;
  int num_errors = 0;
  int check_count = 0;

  ialc_level_ctrl #(.TICK_CYCLES(4)) uut (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_rq), .SMP_VALID_I(smp_v), .SMP_LEFT_I(smp_l), .SMP_RIGHT_I(smp_r),
    .AMP_EN_I(amp_en), .GAIN_LEFT_O(g_l), .GAIN_RIGHT_O(g_r));

  ialc_amp_model amp (.clk_i(clk), .rst_i(rst), .gain_left_i(g_l), .gain_right_i(g_r),
    .lvl_i(lvl), .valid_o(smp_v), .left_o(smp_l), .right_o(smp_r));

  // free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= v;
    // no limit here: only the watchdog ends a hung wait
    do
      @(posedge clk);
    while (wait_rq !== 1'b0);
    d = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic tally_and_finish;
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk({20'h0, g_l, g_r}, 32'h410);
    bus(1'b0, 4'h0, 32'h0);
    chk(d, 32'h1c0);
    bus(1'b0, 4'h4, 32'h0);
    chk(d, 32'h320b);
    bus(1'b1, 4'h8, 32'hffffffff);
    bus(1'b0, 4'h8, 32'h0);
    chk(d, 32'h1010);
    bus(1'b0, 4'hc, 32'h0);
    chk(d, 32'h0);
    // shortest drop and rise intervals, no hold, floor code 1, ceiling code 3
    bus(1'b1, 4'h4, 32'h0000000b);
    lvl <= 20'hc0000;
    bus(1'b1, 4'h0, 32'h0c8);
    wt(600);
    chk({20'h0, g_l, g_r}, 32'h410);
    bus(1'b1, 4'h0, 32'h0cb);
    wt(2000);
    chk({20'h0, g_l, g_r}, 32'h208);
    bus(1'b0, 4'h8, 32'h0);
    chk(32'(d[16]), 32'h0);
    // near full scale: emergency flag, gain held at the floor
    lvl <= 20'hfffff;
    wt(100);
    bus(1'b0, 4'h8, 32'h0);
    chk(32'(d[16]), 32'h1);
    chk({20'h0, g_l, g_r}, 32'h208);
    // silence: gain climbs to the ceiling code 3 limit
    lvl <= 20'h0;
    wt(3000);
    chk({20'h0, g_l, g_r}, 32'h7df);
    // limiter with ceiling 7: captured gain stays the bound
    bus(1'b1, 4'h0, 32'h1cf);
    wt(800);
    chk({20'h0, g_l, g_r}, 32'h7df);
    bus(1'b0, 4'h8, 32'h0);
    chk(32'(d[17]), 32'h1);
    // right amplifier off: its gain freezes while left keeps rising
    amp_en <= 2'h2;
    bus(1'b1, 4'h0, 32'h1cb);
    wt(600);
    chk(32'(g_r), 32'h1f);
    chk(32'(g_l > 6'h1f), 32'h1);
    // right channel only: left output keeps its gain, right follows the loop
    amp_en <= 2'h3;
    bus(1'b1, 4'h0, 32'h1c9);
    wt(1);
    held = g_l;
    wt(400);
    chk(32'(g_l), 32'(held));
    chk(32'(g_r > 6'h1f), 32'h1);
    // left channel only: right output keeps its gain, left follows the loop
    bus(1'b1, 4'h0, 32'h1ca);
    wt(1);
    held = g_r;
    wt(400);
    chk(32'(g_r), 32'(held));
    chk(32'(g_l > held), 32'h1);
    tally_and_finish();
  end

  // watchdog against a hung bus or loop
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : input_automatic_level_control_test
`default_nettype wire
